// ===== src/sawp_regs.svh
// Register offsets, field positions and reset values of the write-protect and address-map block
`ifndef SAWP_REGS_SVH
`define SAWP_REGS_SVH

`define SAWP_MODE_OFF      12'h000
`define SAWP_REFRESH_OFF   12'h004
`define SAWP_CONFIG_OFF    12'h008
`define SAWP_TIMING0_OFF   12'h00c
`define SAWP_TIMING1_OFF   12'h010
`define SAWP_TIMING2_OFF   12'h014
`define SAWP_MEMDEV_OFF    12'h020
`define SAWP_HISPEED_OFF   12'h024
`define SAWP_IRQ_STAT_OFF  12'h030
`define SAWP_IRQ_MASK_OFF  12'h034
`define SAWP_WPMR_OFF      12'h0e4
`define SAWP_WPSR_OFF      12'h0e8

`define SAWP_CFG_COL_LSB   0
`define SAWP_CFG_ROW_LSB   2
`define SAWP_CFG_MAP_BIT   4

`define SAWP_WPMR_EN_BIT   0
`define SAWP_WPSR_FLAG_BIT 0
`define SAWP_WPSR_SRC_LSB  8

`define SAWP_CONFIG_RST    32'h0000_0000
`define SAWP_REG_RST       32'h0000_0000

`define SAWP_COL_BASE      5'd1
`define SAWP_COL_MIN_W     5'd9
`define SAWP_ROW_MIN_W     5'd11
`define SAWP_BANK_W        5'd2
`define SAWP_ADDR_W        28

`endif

// ===== src/sawp_pkg.sv
// Types shared by the write-protect and address-map block
`default_nettype none
package sawp_pkg;
    typedef struct packed {
        logic [1:0] col_sel;
        logic [1:0] row_sel;
        logic interleave;
    } sawp_geom_t;

    typedef struct packed {
        logic [1:0] bank;
        logic [13:0] row;
        logic [11:0] col;
        logic byte_lane_select_bit;
    } sawp_map_t;

    typedef enum logic [2:0] {
        SAWP_IDLE = 3'b001,
        SAWP_ACCESS = 3'b010,
        SAWP_DONE = 3'b100
    } sawp_apb_st_t;
endpackage
`default_nettype wire

// ===== src/sawp_addr_map.sv
// Combinational split of a system byte address into bank, row and column
`include "sawp_regs.svh"
`default_nettype none
module sawp_addr_map (
    input wire logic [27:0] addr,
    input wire sawp_pkg::sawp_geom_t geom,
    output sawp_pkg::sawp_map_t map
);
    logic [4:0] col_w;
    logic [4:0] row_w;
    logic [4:0] above_col;
    logic [4:0] above_row;
    logic [4:0] bank_lsb;
    logic [4:0] row_lsb;
    logic [27:0] shr;
    logic [27:0] shb;
    logic [13:0] row_mask;
    logic [11:0] col_mask;

    always_comb begin
        col_w = `SAWP_COL_MIN_W + {3'b000, geom.col_sel};
        // 16K rows with 4096 columns arrive here as 8K rows, so the address stays in 28 bits
        row_w = `SAWP_ROW_MIN_W + {3'b000, geom.row_sel};
        above_col = `SAWP_COL_BASE + col_w;
        above_row = above_col + row_w;
        if (geom.interleave) begin
            bank_lsb = above_col;
            row_lsb = above_col + `SAWP_BANK_W;
        end else begin
            bank_lsb = above_row;
            row_lsb = above_col;
        end
        shr = addr >> row_lsb;
        shb = addr >> bank_lsb;
        row_mask = 14'(({14'h0001} << row_w) - 14'h0001);
        col_mask = 12'(({13'h0001} << col_w) - 13'h0001);
        map.byte_lane_select_bit = addr[0];
        map.col = addr[12:1] & col_mask;
        // Upper address bits drop out, so the image repeats
        map.row = shr[13:0] & row_mask;
        map.bank = shb[1:0];
    end
endmodule
`default_nettype wire

// ===== src/sawp_top.sv
// Register write protection and address mapping for a multiport SDRAM controller
`include "sawp_regs.svh"
`default_nettype none
module sawp_top (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic [27:0] SYS_ADDR,
    output logic [1:0] MAP_BANK,
    output logic [13:0] MAP_ROW,
    output logic [11:0] MAP_COL,
    output logic MAP_BYTE_LANE,
    output logic [31:0] MODE_CFG,
    output logic [31:0] REFRESH_CFG
);
    logic [31:0] regs_ff [0:7];
    logic protect_enable_bit_ff;
    logic protect_violation_flag_ff;
    logic [3:0] violation_source_field_ff;
    logic irq_stat_ff;
    logic irq_mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic [1:0] bank_ff;
    logic [13:0] row_ff;
    logic [11:0] col_ff;
    logic lane_ff;
    logic [31:0] nxt_prdata;
    logic nxt_slverr;
    logic prot_hit;
    logic [2:0] prot_idx;
    logic wr_take;
    logic rd_take;
    logic blocked;
    logic status_read;
    sawp_pkg::sawp_geom_t geom;
    sawp_pkg::sawp_map_t map;
    logic [1:0] row_sel_raw;

    // One-wait answer: access phase gets PREADY in its second cycle
    assign wr_take = PSEL && PENABLE && pready_ff && PWRITE;
    assign rd_take = PSEL && PENABLE && pready_ff && !PWRITE;

    always_comb begin
        prot_hit = 1'b1;
        prot_idx = 3'd0;
        unique case (PADDR)
            `SAWP_MODE_OFF: prot_idx = 3'd0;
            `SAWP_REFRESH_OFF: prot_idx = 3'd1;
            `SAWP_CONFIG_OFF: prot_idx = 3'd2;
            `SAWP_TIMING0_OFF: prot_idx = 3'd3;
            `SAWP_TIMING1_OFF: prot_idx = 3'd4;
            `SAWP_TIMING2_OFF: prot_idx = 3'd5;
            `SAWP_MEMDEV_OFF: prot_idx = 3'd6;
            `SAWP_HISPEED_OFF: prot_idx = 3'd7;
            default: prot_hit = 1'b0;
        endcase
    end

    assign blocked = wr_take && prot_hit && protect_enable_bit_ff;
    assign status_read = rd_take && PADDR == `SAWP_WPSR_OFF;

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (prot_hit) begin
            nxt_prdata = regs_ff[prot_idx];
        end else begin
            unique case (PADDR)
                `SAWP_WPMR_OFF: nxt_prdata[`SAWP_WPMR_EN_BIT] = protect_enable_bit_ff;
                `SAWP_WPSR_OFF: begin
                    nxt_prdata[`SAWP_WPSR_FLAG_BIT] = protect_violation_flag_ff;
                    nxt_prdata[`SAWP_WPSR_SRC_LSB +: 4] = violation_source_field_ff;
                end
                `SAWP_IRQ_STAT_OFF: nxt_prdata[0] = irq_stat_ff;
                `SAWP_IRQ_MASK_OFF: nxt_prdata[0] = irq_mask_ff;
                default: nxt_slverr = 1'b1;
            endcase
        end
    end

    // APB answer: PREADY pulses in the second access cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= PSEL && PENABLE && !pready_ff;
            if (PSEL && PENABLE && !pready_ff) begin
                prdata_ff <= PWRITE ? 32'h0000_0000 : nxt_prdata;
                pslverr_ff <= nxt_slverr;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < 8; i++) begin
                regs_ff[i] <= `SAWP_REG_RST;
            end
        end else if (wr_take && prot_hit && !blocked) begin
            regs_ff[prot_idx] <= PWDATA;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            protect_enable_bit_ff <= 1'b0;
        end else if (wr_take && PADDR == `SAWP_WPMR_OFF) begin
            protect_enable_bit_ff <= PWDATA[`SAWP_WPMR_EN_BIT];
        end
    end

    // A new violation in the reading cycle wins over the clear
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            protect_violation_flag_ff <= 1'b0;
            violation_source_field_ff <= 4'h0;
        end else if (blocked) begin
            protect_violation_flag_ff <= 1'b1;
            violation_source_field_ff <= PADDR[5:2];
        end else if (status_read) begin
            protect_violation_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_stat_ff <= 1'b0;
            irq_mask_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            if (blocked) begin
                irq_stat_ff <= 1'b1;
            end else if (wr_take && PADDR == `SAWP_IRQ_STAT_OFF && PWDATA[0]) begin
                irq_stat_ff <= 1'b0;
            end
            if (wr_take && PADDR == `SAWP_IRQ_MASK_OFF) begin
                irq_mask_ff <= PWDATA[0];
            end
            irq_ff <= irq_stat_ff && irq_mask_ff;
        end
    end

    // 16K rows with 4096 columns would overflow 28 bits; fall back to 8K rows
    always_comb begin
        row_sel_raw = regs_ff[2][`SAWP_CFG_ROW_LSB +: 2];
        geom.col_sel = regs_ff[2][`SAWP_CFG_COL_LSB +: 2];
        geom.interleave = regs_ff[2][`SAWP_CFG_MAP_BIT];
        geom.row_sel = (row_sel_raw == 2'd3 && geom.col_sel == 2'd3) ? 2'd2 : row_sel_raw;
    end

    sawp_addr_map u_map (
        .addr(SYS_ADDR),
        .geom(geom),
        .map(map)
    );

    // SYS_ADDR comes from same-clock logic; result registered one cycle later
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bank_ff <= 2'b00;
            row_ff <= 14'h0000;
            col_ff <= 12'h000;
            lane_ff <= 1'b0;
        end else begin
            bank_ff <= map.bank;
            row_ff <= map.row;
            col_ff <= map.col;
            lane_ff <= map.byte_lane_select_bit;
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign IRQ = irq_ff;
    assign MAP_BANK = bank_ff;
    assign MAP_ROW = row_ff;
    assign MAP_COL = col_ff;
    assign MAP_BYTE_LANE = lane_ff;
    assign MODE_CFG = regs_ff[0];
    assign REFRESH_CFG = regs_ff[1];
endmodule
`default_nettype wire

// ===== tb/sawp_checker.sv
// Concurrent checks on the ports of the write-protect and address-map block
`default_nettype none
module sawp_checker (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic IRQ,
    input wire logic [27:0] SYS_ADDR,
    input wire logic [11:0] MAP_COL,
    input wire logic MAP_BYTE_LANE,
    input wire logic [31:0] MODE_CFG,
    input wire logic [31:0] REFRESH_CFG
);
    logic wp_en_ff;
    logic wr;
    assign wr = PSEL && PENABLE && PREADY && PWRITE;
    // Shadow of the protect enable, so locking is judged from the bus alone
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wp_en_ff <= 1'b0;
        end else if (wr && PADDR == 12'h0e4) begin
            wp_en_ff <= PWDATA[0];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    property p_wait; PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY; endproperty
    a_wait: assert property (p_wait) else $error("ready not after one wait");
    property p_rdy; PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE); endproperty
    a_rdy: assert property (p_rdy) else $error("ready outside access");
    property p_lane; $past(RESET_N) |-> MAP_BYTE_LANE == $past(SYS_ADDR[0]); endproperty
    a_lane: assert property (p_lane) else $error("byte lane");
    property p_col; $past(RESET_N) |-> MAP_COL[8:0] == $past(SYS_ADDR[9:1]); endproperty
    a_col: assert property (p_col) else $error("column bits");
    property p_mlock; wr && PADDR == 12'h000 && wp_en_ff |=> $stable(MODE_CFG); endproperty
    a_mlock: assert property (p_mlock) else $error("mode written while locked");
    property p_rlock; wr && PADDR == 12'h004 && wp_en_ff |=> $stable(REFRESH_CFG); endproperty
    a_rlock: assert property (p_rlock) else $error("refresh written while locked");
    property p_mwr; wr && PADDR == 12'h000 && !wp_en_ff |=> MODE_CFG == $past(PWDATA); endproperty
    a_mwr: assert property (p_mwr) else $error("mode write lost");
    property p_irq; $rose(IRQ) |-> $past(wr) || $past(wr, 2); endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
    c_lock: cover property (wr && wp_en_ff && PADDR == 12'h004);
    c_irq: cover property ($rose(IRQ));
    c_map: cover property ($changed(MAP_COL));
endmodule
`default_nettype wire

// ===== tb/sawp_mem_model.sv
// Far-side memory: remembers the open row of each bank
`default_nettype none
module sawp_mem_model (
    input wire logic clk,
    input wire logic [1:0] bank,
    input wire logic [13:0] row
);
    logic [13:0] open_row [4];
    // A row change would cost precharge plus activate in a real part
    always @(posedge clk) open_row[bank] <= row;
endmodule
`default_nettype wire

// ===== tb/sdram_addr_map_write_protect_tb_top.sv
// Testbench for the write-protect and address-map block
`default_nettype none
module sdram_addr_map_write_protect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [27:0] sa = 28'h0;
    logic [31:0] prd, mode, refr;
    logic rdy, err, irq, lane;
    logic [1:0] bank;
    logic [13:0] row;
    logic [11:0] col;
    int error_cnt = 0;
    int tests_run = 0;
    logic [11:0] prot [8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h020, 12'h024};
    logic [27:0] adr [3] = '{28'h5a5a5a5, 28'ha5a5a5a, 28'hfffffff};
    always #2 clk = ~clk;
    sawp_top dut (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .IRQ(irq), .SYS_ADDR(sa), .MAP_BANK(bank),
        .MAP_ROW(row), .MAP_COL(col), .MAP_BYTE_LANE(lane), .MODE_CFG(mode), .REFRESH_CFG(refr));
    sawp_mem_model u_mem (.clk(clk), .bank(bank), .row(row));
    task automatic finish_test();
        $display("Errors %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
        input logic e);
        int n;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            $display("Error at %0t: no ready", $time);
            finish_test();
        end else begin
            if (!w) chk(prd, exp);
            chk({31'h0, err}, {31'h0, e});
            psel <= 1'b0;
            pen <= 1'b0;
            // One idle edge, so the next call never drives psel twice in one step
            @(posedge clk);
        end
    endtask
    // Expected {bank, row, column, lane}, worked out from the field order
    function automatic logic [31:0] exp_map(input logic [4:0] c, input logic [27:0] a);
        int cw, rw;
        logic [27:0] s, cm, rm, bk, r;
        cw = 9 + c[1:0];
        rw = (c[3:0] == 4'hf) ? 13 : 11 + c[3:2];
        s = a >> 1;
        cm = s & ((28'h1 << cw) - 1);
        s = s >> cw;
        rm = (28'h1 << rw) - 1;
        bk = c[4] ? s & 3 : (s >> rw) & 3;
        r = c[4] ? (s >> 2) & rm : s & rm;
        return {3'h0, bk[1:0], r[13:0], cm[11:0], a[0]};
    endfunction
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(0, 12'h040, 0, 32'h0, 1);
        foreach (prot[i]) apb(1, prot[i], {20'h0, prot[i]}, 0, 0);
        apb(1, 12'h034, 32'h1, 0, 0);
        apb(1, 12'h0e4, 32'h1, 0, 0);
        foreach (prot[i]) begin
            apb(1, prot[i], 32'hffffffff, 0, 0);
            apb(0, prot[i], 0, {20'h0, prot[i]}, 0);
            apb(0, 12'h0e8, 0, {20'h0, prot[i][5:2], 8'h1}, 0);
            apb(0, 12'h0e8, 0, {20'h0, prot[i][5:2], 8'h0}, 0);
            chk({31'h0, irq}, 32'h1);
            apb(1, 12'h030, 32'h1, 0, 0);
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
        end
        chk(refr, 32'h4);
        apb(1, 12'h034, 32'h0, 0, 0);
        apb(1, 12'h000, 32'h5, 0, 0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(0, 12'h030, 0, 32'h1, 0);
        apb(1, 12'h0e4, 32'h0, 0, 0);
        apb(1, 12'h000, 32'h1234abcd, 0, 0);
        chk(mode, 32'h1234abcd);
        for (int c = 0; c < 32; c++) begin
            apb(1, 12'h008, c, 0, 0);
            foreach (adr[k]) begin
                sa <= adr[k];
                repeat (2) @(posedge clk);
                chk({3'h0, bank, row, col, lane}, exp_map(c[4:0], adr[k]));
            end
        end
        finish_test();
    end
    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        $display("Error at %0t: timeout", $time);
        finish_test();
    end
endmodule
bind sawp_top sawp_checker u_chk (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .IRQ(IRQ), .SYS_ADDR(SYS_ADDR),
    .MAP_COL(MAP_COL), .MAP_BYTE_LANE(MAP_BYTE_LANE), .MODE_CFG(MODE_CFG), .REFRESH_CFG(REFRESH_CFG));
`default_nettype wire
